/* flash_prot_params.svh */
// Offsets, field positions, reset values and timing counts for the flash protection block.
`ifndef FLASH_PROT_PARAMS_SVH
`define FLASH_PROT_PARAMS_SVH

`define FPE_OFF_MODE      8'h00
`define FPE_OFF_SEL_HI    8'h04
`define FPE_OFF_SEL_LO    8'h08
`define FPE_OFF_OVERLAP   8'h0c
`define FPE_OFF_STATUS    8'h10

`define FPE_BIT_PROG      0
`define FPE_BIT_ERASE     1
`define FPE_BIT_WCHK      2
`define FPE_BIT_CCHK      3
`define FPE_BIT_OVL_HI    7
`define FPE_BIT_OVL_LO    6

`define FPE_RST_MODE      4'h0
`define FPE_RST_SEL_HI    8'hf0
`define FPE_RST_SEL_LO    8'h00
`define FPE_RST_OVERLAP   8'h08

`define FPE_BLOCKS        12
`define FPE_CLK_NS        10
`define FPE_SETTLE_NS     4000
`define FPE_SETTLE_CYC    ((`FPE_SETTLE_NS + `FPE_CLK_NS - 1) / `FPE_CLK_NS)

`endif

/* flash_prot_pkg.sv */
// Types shared by the flash protection block.
package flash_prot_pkg;

	typedef enum logic [1:0] {
		op_idle,
		op_program,
		op_erase,
		op_aborted
	} op_state_t;

endpackage

/* flash_program_erase_protect.sv */
// Flash program and erase protection, verify-mode control and APB register file.
`timescale 1ns/1ns
`include "flash_prot_params.svh"

module flash_program_erase_protect #(
	parameter int BLOCKS = `FPE_BLOCKS
) (
	input  wire logic                      clk_sys,
	input  wire logic                      rst_b,
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [7:0]                paddr,
	input  wire logic [31:0]               pwdata,
	output logic      [31:0]               prdata,
	output logic                           pready,
	output logic                           pslverr,
	input  wire logic                      program_voltage_pin,
	input  wire logic                      standby_req,
	input  wire logic                      watchdog_reset,
	input  wire logic                      irq_req,
	output logic                           program_drive,
	output logic                           erase_drive,
	output logic      [BLOCKS-1:0]         block_enable,
	output logic                           write_check_mode,
	output logic                           clear_check_mode,
	output logic                           prewrite_check_mode,
	output logic                           verify_ready,
	output logic                           abort_flag,
	output flash_prot_pkg::op_state_t      op_state
);
	import flash_prot_pkg::*;

	if (BLOCKS < 9 || BLOCKS > 16) begin : g_bad_blocks
		$error("BLOCKS must lie between 9 and 16.");
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register and synchroniser state.

	localparam int HI_W = BLOCKS - 8;
	localparam logic [8:0] SETTLE_CYC = 9'(`FPE_SETTLE_CYC);

	logic              vpp_s1_reg;
	logic              vpp_s2_reg;
	logic [3:0]        mode_reg;
	logic [3:0]        mode_next;
	logic [7:0]        sel_hi_reg;
	logic [7:0]        sel_hi_next;
	logic [7:0]        sel_lo_reg;
	logic [7:0]        sel_lo_next;
	logic [7:0]        overlap_reg;
	logic [7:0]        overlap_next;
	logic              abort_reg;
	logic              abort_next;
	logic [8:0]        settle_reg;
	logic [8:0]        settle_next;
	op_state_t         op_state_next;

	// Address decode is shared by the read mux and the write strobes.
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// APB decode.

	// Writes commit only in the access cycle that the slave marks ready.
	wire   setup_cyc  = psel & ~penable;
	wire   wr_cyc     = psel & penable & pready & pwrite;
	wire   hit_mode   = hit(paddr, `FPE_OFF_MODE);
	wire   hit_hi     = hit(paddr, `FPE_OFF_SEL_HI);
	wire   hit_lo     = hit(paddr, `FPE_OFF_SEL_LO);
	wire   hit_ovl    = hit(paddr, `FPE_OFF_OVERLAP);
	wire   hit_stat   = hit(paddr, `FPE_OFF_STATUS);
	wire   mapped     = hit_mode | hit_hi | hit_lo | hit_ovl | hit_stat;
	wire   wr_mode    = wr_cyc & hit_mode;
	wire   wr_hi      = wr_cyc & hit_hi;
	wire   wr_lo      = wr_cyc & hit_lo;
	wire   wr_ovl     = wr_cyc & hit_ovl;

	////////////////////////////////////////////////////////////////////////////////
	// Protection terms.

	// Unused high select bits read as one, so an empty selection reads H'F0.
	wire [7:0]        hi_fixed   = 8'hff << HI_W;
	wire              vpp_ok     = vpp_s2_reg;
	wire              hard_clear = ~vpp_ok | standby_req | watchdog_reset;
	wire              emul_prot  = overlap_reg[`FPE_BIT_OVL_HI] ^ overlap_reg[`FPE_BIT_OVL_LO];
	wire              all_off    = (sel_hi_reg == `FPE_RST_SEL_HI) && (sel_lo_reg == `FPE_RST_SEL_LO);
	wire [BLOCKS-1:0] sel_blocks = {sel_hi_reg[HI_W-1:0], sel_lo_reg};
	wire              soft_prot  = emul_prot | all_off | abort_reg;
	wire              p_bit      = mode_reg[`FPE_BIT_PROG];
	wire              e_bit      = mode_reg[`FPE_BIT_ERASE];
	wire              pv_bit     = mode_reg[`FPE_BIT_WCHK];
	wire              ev_bit     = mode_reg[`FPE_BIT_CCHK];

	// An interrupt while a pulse is live aborts it within the same cycle's update.
	wire              irq_abort  = irq_req & (program_drive | erase_drive);
	wire              drive_ok   = ~soft_prot & ~hard_clear & ~irq_abort;
	wire              prog_next  = drive_ok & p_bit & ~e_bit;
	wire              erase_next = drive_ok & e_bit & ~p_bit;

	// Verify modes survive block, emulation and abort protection only.
	wire              verify_ok  = ~hard_clear;
	wire              wchk_next  = verify_ok & pv_bit & ~p_bit & ~e_bit;
	wire              cchk_next  = verify_ok & ev_bit & ~pv_bit & ~p_bit & ~e_bit;
	wire              pre_next   = verify_ok & (mode_reg == 4'h0);

	////////////////////////////////////////////////////////////////////////////////
	// Next-state of the software registers.

	// Hardware clearing outranks a software write in the same cycle.
	always_comb begin
		mode_next = mode_reg;
		if (hard_clear) begin
			mode_next = `FPE_RST_MODE;
		end else if (wr_mode && !abort_reg) begin
			mode_next = pwdata[3:0];
		end
	end

	always_comb begin
		sel_hi_next = sel_hi_reg;
		sel_lo_next = sel_lo_reg;
		if (hard_clear) begin
			sel_hi_next = `FPE_RST_SEL_HI;
			sel_lo_next = `FPE_RST_SEL_LO;
		end else if (!abort_reg) begin
			if (wr_hi) begin
				sel_hi_next = pwdata[7:0] | hi_fixed;
			end
			if (wr_lo) begin
				sel_lo_next = pwdata[7:0];
			end
		end
	end

	// The overlap register only follows a full reset, not the voltage pin or standby.
	always_comb begin
		overlap_next = overlap_reg;
		if (watchdog_reset) begin
			overlap_next = `FPE_RST_OVERLAP;
		end else if (wr_ovl) begin
			overlap_next = pwdata[7:0];
		end
	end

	// Abort is sticky; only a reset releases it, and a new abort wins over a watchdog reset in the same cycle.
	always_comb begin
		abort_next = abort_reg;
		if (irq_abort) begin
			abort_next = 1'b1;
		end else if (watchdog_reset) begin
			abort_next = 1'b0;
		end
	end

	// Counts the settle time after prewrite-verify is entered.
	always_comb begin
		settle_next = settle_reg;
		if (!pre_next) begin
			settle_next = 9'h000;
		end else if (settle_reg != SETTLE_CYC) begin
			settle_next = settle_reg + 9'h001;
		end
	end

	always_comb begin
		op_state_next = op_idle;
		if (abort_next) begin
			op_state_next = op_aborted;
		end else if (prog_next) begin
			op_state_next = op_program;
		end else if (erase_next) begin
			op_state_next = op_erase;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read mux.

	wire [31:0] status_word = {25'h0, op_state, verify_ready, abort_reg, emul_prot, all_off, vpp_ok};
	wire [31:0] rd_word =
		hit_mode ? {28'h0, mode_reg} :
		hit_hi   ? {24'h0, sel_hi_reg} :
		hit_lo   ? {24'h0, sel_lo_reg} :
		hit_ovl  ? {24'h0, overlap_reg} :
		hit_stat ? status_word : 32'h0000_0000;

	////////////////////////////////////////////////////////////////////////////////
	// Flip-flops.

	// The voltage pin is asynchronous; only the second stage is read.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			vpp_s1_reg <= 1'b0;
			vpp_s2_reg <= 1'b0;
		end else begin
			vpp_s1_reg <= program_voltage_pin;
			vpp_s2_reg <= vpp_s1_reg;
		end
	end

	// Zero-wait slave: ready in the first access cycle, data captured at setup.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= setup_cyc;
			pslverr <= setup_cyc & ~mapped;
			if (setup_cyc) begin
				prdata <= rd_word;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			mode_reg    <= `FPE_RST_MODE;
			sel_hi_reg  <= `FPE_RST_SEL_HI;
			sel_lo_reg  <= `FPE_RST_SEL_LO;
			overlap_reg <= `FPE_RST_OVERLAP;
			abort_reg   <= 1'b0;
			settle_reg  <= 9'h000;
		end else begin
			mode_reg    <= mode_next;
			sel_hi_reg  <= sel_hi_next;
			sel_lo_reg  <= sel_lo_next;
			overlap_reg <= overlap_next;
			abort_reg   <= abort_next;
			settle_reg  <= settle_next;
		end
	end

	// Block enables reach the array only; overlapped RAM is never gated here.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			program_drive       <= 1'b0;
			erase_drive         <= 1'b0;
			block_enable        <= '0;
			write_check_mode    <= 1'b0;
			clear_check_mode    <= 1'b0;
			prewrite_check_mode <= 1'b0;
			verify_ready        <= 1'b0;
			abort_flag          <= 1'b0;
			op_state            <= op_idle;
		end else begin
			program_drive       <= prog_next;
			erase_drive         <= erase_next;
			block_enable        <= sel_blocks & {BLOCKS{prog_next | erase_next}};
			write_check_mode    <= wchk_next;
			clear_check_mode    <= cchk_next;
			prewrite_check_mode <= pre_next;
			verify_ready        <= pre_next && (settle_next == SETTLE_CYC);
			abort_flag          <= abort_next;
			op_state            <= op_state_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Assertions.

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	a_emul_blocks_drive: assert property (emul_prot |=> !program_drive && !erase_drive)
		else $error("Drive active under emulation protection.");

	a_all_blocks_off: assert property (all_off |=> !program_drive && !erase_drive)
		else $error("Drive active with every block deselected.");

	a_block_match: assert property (program_drive || erase_drive |-> block_enable != '0)
		else $error("Drive active with no block enabled.");

	a_vpp_clears_regs: assert property (!vpp_s2_reg |=> mode_reg == 4'h0 && sel_lo_reg == 8'h00
		&& !prewrite_check_mode)
		else $error("Registers or verify kept without programming voltage.");

	a_standby_clears: assert property (standby_req |=> mode_reg == 4'h0 && sel_hi_reg == 8'hf0
		&& !program_drive && !write_check_mode)
		else $error("Standby did not clear the flash controls.");

	a_irq_aborts: assert property (irq_req && (program_drive || erase_drive)
		|=> !program_drive && !erase_drive && abort_flag)
		else $error("Interrupt did not abort the pulse.");

	a_abort_holds: assert property (abort_reg && !hard_clear |=> $stable(mode_reg)
		&& $stable(sel_lo_reg) && !program_drive && !erase_drive)
		else $error("Registers changed or drive resumed after abort.");

	a_prewrite_entry: assert property (mode_reg == 4'h0 && !hard_clear |=> prewrite_check_mode)
		else $error("Prewrite verify not entered with all bits clear.");

	a_verify_survives: assert property (pv_bit && !p_bit && !e_bit && !hard_clear && soft_prot
		|=> write_check_mode)
		else $error("Software protection disabled verify.");

	a_drive_cause: assert property (program_drive |-> $past(p_bit) && !$past(soft_prot))
		else $error("Program drive without its pulse bit or under protection.");

	a_settle_wait: assert property ($rose(prewrite_check_mode) |-> !verify_ready [*8])
		else $error("Prewrite data flagged ready too early.");

	// Further guards on drive causes, block gating, abort and verify levels.
	// The cause and subset guards tie an output to the register state that the edge before presented.

	a_erase_cause: assert property (erase_drive |-> $past(e_bit) && !$past(soft_prot))
		else $error("Erase drive without its pulse bit or under protection.");

	a_one_drive: assert property (!(program_drive && erase_drive))
		else $error("Program and erase drive both active.");

	a_block_subset: assert property ((block_enable & ~$past(sel_blocks)) == '0)
		else $error("Unselected block enabled.");

	a_hard_no_drive: assert property (hard_clear |=> !program_drive && !erase_drive
		&& block_enable == '0)
		else $error("Drive or block enable kept under hardware protection.");

	a_hard_kills_verify: assert property (hard_clear |=> !write_check_mode && !clear_check_mode
		&& !prewrite_check_mode)
		else $error("Verify mode kept under hardware protection.");

	a_clear_check_on: assert property (ev_bit && !pv_bit && !p_bit && !e_bit && !hard_clear
		|=> clear_check_mode)
		else $error("Clear check mode not entered.");

	a_abort_sticky: assert property (abort_flag && !watchdog_reset |=> abort_flag)
		else $error("Abort released without a reset.");

	a_abort_state: assert property (abort_flag |-> op_state == op_aborted)
		else $error("Abort not shown in the operation state.");

	a_ready_after_settle: assert property (verify_ready |-> prewrite_check_mode
		&& settle_reg == SETTLE_CYC)
		else $error("Prewrite data flagged ready before the settle count.");

	c_clear_check: cover property ($rose(clear_check_mode));
	c_program_pulse: cover property (program_drive [*3]);
	c_erase_pulse: cover property (erase_drive ##1 !erase_drive);
	c_irq_abort: cover property (irq_req && program_drive ##1 abort_flag);
	c_prewrite_ready: cover property ($rose(verify_ready));

endmodule

/* cpu_model.sv */
// Processor-side bus master that runs the program, erase and verify sequences.
`timescale 1ns/1ns
`include "flash_prot_params.svh"

module cpu_model #(
	parameter int LOOP_MHZ = 10
) (
	input  wire logic        clk_sys,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	logic [31:0] rd_data;
	logic        rd_err;
	logic [15:0] wdt_setting;

	// The bus is idle at time zero.
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		wdt_setting = 16'h0000;
	end

	////////////////////////////////////////////////////////////////////////////
	// One transfer; the request stands until pready is seen high at an edge.
	// The slave's answer time is not assumed; only the bench's watchdog ends a hung wait.
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
		end while (pready !== 1'b1);
		rd_data = prdata;
		rd_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Released lines carry the inverse so stale values are never trusted.
		paddr <= ~a;
		pwdata <= ~d;
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Loop counts scale from the 10 MHz figures; pulses round down, settle waits round up.
	function automatic int scaled(input int base, input bit up);
		scaled = (base * LOOP_MHZ + (up ? 9 : 0)) / 10;
	endfunction

	// Watchdog overflow word that the routine loads before each pulse.
	function automatic logic [15:0] wdt_word();
		wdt_word = (LOOP_MHZ >= 10) ? 16'ha57f : 16'ha57e;
	endfunction

	// One pulse: set the bit, count the loop, clear the bit.
	// Nothing runs between arming and disarming the watchdog, so its overflow word stays valid.
	task automatic pulse(input logic [31:0] bits, input int loops);
		wdt_setting = wdt_word();
		xfer(1'b1, `FPE_OFF_MODE, bits);
		repeat (loops) @(posedge clk_sys);
		xfer(1'b1, `FPE_OFF_MODE, 32'h0);
	endtask
endmodule

/* tb_top.sv */
// Self-checking bench for the flash program and erase protection block.
`timescale 1ns/1ns
`include "flash_prot_params.svh"

module tb_top;
	import flash_prot_pkg::*;
	logic        clk_sys = 1'b0;
	logic        rst_b = 1'b0;
	logic        program_voltage_pin = 1'b0;
	logic        standby_req = 1'b0;
	logic        watchdog_reset = 1'b0;
	logic        irq_req = 1'b0;
	logic        psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr, hi, lo;
	logic [31:0] pwdata, prdata, rv;
	logic        program_drive, erase_drive, verify_ready, abort_flag;
	logic        write_check_mode, clear_check_mode, prewrite_check_mode;
	logic [11:0] block_enable, e;
	logic [1:0]  ovl, pb;
	op_state_t   op_state;
	int          miscompares = 0;
	int          n_tests = 0;
	int          seed = 32'haf32eca6;

	flash_program_erase_protect flash_program_erase_protect_i (.clk_sys(clk_sys), .rst_b(rst_b),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .program_voltage_pin(program_voltage_pin),
		.standby_req(standby_req), .watchdog_reset(watchdog_reset), .irq_req(irq_req),
		.program_drive(program_drive), .erase_drive(erase_drive), .block_enable(block_enable),
		.write_check_mode(write_check_mode), .clear_check_mode(clear_check_mode),
		.prewrite_check_mode(prewrite_check_mode), .verify_ready(verify_ready),
		.abort_flag(abort_flag), .op_state(op_state));

	cpu_model cpu_model_i (.clk_sys(clk_sys), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

	// Free-running system clock.
	always #5 clk_sys = ~clk_sys;

	////////////////////////////////////////////////////////////////////////////
	// Shared helpers for comparisons, bus access and waiting.
	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		n_tests++;
		if (got !== ex) begin
			miscompares++;
			$display("unexpected %s: expected %h, seen %h", nm, ex, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		cpu_model_i.xfer(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		cpu_model_i.xfer(1'b0, a, 32'h0);
		d = cpu_model_i.rd_data;
	endtask

	// Outputs are looked at one nanosecond past the edge, once they have settled.
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	task automatic arm(input logic [7:0] h, input logic [7:0] l, input logic [1:0] o, input logic [1:0] m);
		wr(`FPE_OFF_SEL_HI, {24'h0, h});
		wr(`FPE_OFF_SEL_LO, {24'h0, l});
		wr(`FPE_OFF_OVERLAP, {24'h0, o, 6'h08});
		wr(`FPE_OFF_MODE, {30'h0, m});
		cyc(2);
	endtask

	// Blocks that should see a pulse; one overlap bit alone shuts every block.
	function automatic logic [11:0] exp_blk(input logic [7:0] h, input logic [7:0] l,
		input logic [1:0] o, input logic [1:0] m);
		if (^o || (m != 2'b01 && m != 2'b10)) begin
			return 12'h000;
		end
		return {h[3:0], l};
	endfunction

	task automatic end_of_test();
		$display("comparisons %0d, mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial begin
		repeat (2) @(posedge clk_sys);
		rst_b <= 1'b1;
		program_voltage_pin <= 1'b1;
		rd(`FPE_OFF_MODE, rv);
		chk("mode", 32'h0, rv);
		rd(`FPE_OFF_SEL_HI, rv);
		chk("sel_hi", 32'hf0, rv);
		rd(`FPE_OFF_OVERLAP, rv);
		chk("overlap", 32'h08, rv);
		rd(8'h20, rv);
		chk("slverr", 32'h1, {31'h0, cpu_model_i.rd_err});
		wr(`FPE_OFF_STATUS, 32'hffffffff);
		rd(`FPE_OFF_STATUS, rv);
		chk("status", 32'h03, rv & 32'h6f);
		$display("test registers done");
		// Verify modes stay usable while every block is protected.
		for (int i = 0; i < 3; i++) begin
			wr(`FPE_OFF_MODE, 32'(i * 4));
			cyc(2);
			chk("verify", 32'h1 << i, {clear_check_mode, write_check_mode, prewrite_check_mode});
		end
		wr(`FPE_OFF_MODE, 32'h1);
		cyc(2);
		chk("protected", 32'h0, {program_drive, erase_drive});
		wr(`FPE_OFF_MODE, 32'h0);
		cyc(`FPE_SETTLE_CYC - 2);
		chk("early", 32'h0, verify_ready);
		cyc(5);
		chk("settled", 32'h1, verify_ready);
		$display("test verify done");
		// Random selections, first the four overlap settings as corners.
		for (int i = 0; i < 12; i++) begin
			hi = 8'($random(seed));
			lo = 8'($random(seed));
			ovl = 2'($random(seed));
			pb = 2'($random(seed));
			if (i < 4) begin
				ovl = i[1:0];
				pb = 2'b01;
				lo = 8'h5a;
			end
			arm(hi, lo, ovl, pb);
			e = exp_blk(hi, lo, ovl, pb);
			chk("blocks", e, block_enable);
			chk("drives", {pb == 2'b10 && e != 0, pb == 2'b01 && e != 0}, {erase_drive, program_drive});
			wr(`FPE_OFF_MODE, 32'h0);
		end
		$display("test selection done");
		// Erase corner: the selected blocks are prewritten to zero first, then one erase pulse.
		arm(8'h0f, 8'hff, 2'b00, 2'b00);
		cpu_model_i.pulse(32'h1, cpu_model_i.scaled(25, 1'b0));
		cyc(cpu_model_i.scaled(7, 1'b1));
		chk("prewrite", 32'h1, {program_drive, prewrite_check_mode});
		fork
			cpu_model_i.pulse(32'h2, cpu_model_i.scaled(6250, 1'b0));
			begin
				cyc(8);
				chk("erase", exp_blk(8'h0f, 8'hff, 2'b00, 2'b10), block_enable & {12{erase_drive}});
			end
		join
		cyc(2);
		chk("erased", 32'h0, {erase_drive, block_enable});
		chk("watchdog", 32'ha57f, {16'h0, cpu_model_i.wdt_setting});
		$display("test erase done");
		arm(8'h00, 8'h01, 2'b00, 2'b01);
		@(posedge clk_sys);
		irq_req <= 1'b1;
		@(posedge clk_sys);
		irq_req <= 1'b0;
		cyc(1);
		chk("abort", 32'h1, {program_drive, abort_flag});
		wr(`FPE_OFF_MODE, 32'h0);
		rd(`FPE_OFF_MODE, rv);
		chk("held", 32'h1, rv);
		chk("state", op_aborted, {30'h0, op_state});
		@(posedge clk_sys);
		watchdog_reset <= 1'b1;
		@(posedge clk_sys);
		watchdog_reset <= 1'b0;
		cyc(2);
		rd(`FPE_OFF_MODE, rv);
		chk("cleared", 32'h0, {rv[30:0], abort_flag});
		$display("test abort done");
		// Pin low, standby and watchdog reset each clear the controls.
		for (int k = 0; k < 3; k++) begin
			arm(8'h01, 8'h80, 2'b00, 2'b01);
			@(posedge clk_sys);
			program_voltage_pin <= (k != 0);
			standby_req <= (k == 1);
			watchdog_reset <= (k == 2);
			cyc(4);
			chk("hard", 32'h0, {program_drive, block_enable, prewrite_check_mode});
			@(posedge clk_sys);
			program_voltage_pin <= 1'b1;
			standby_req <= 1'b0;
			watchdog_reset <= 1'b0;
			rd(`FPE_OFF_SEL_LO, rv);
			chk("sel_lo", 32'h0, rv);
		end
		$display("test hardware done");
		wr(`FPE_OFF_MODE, 32'h4);
		@(posedge clk_sys);
		rst_b <= 1'b0;
		repeat (10) @(posedge clk_sys);
		rst_b <= 1'b1;
		cyc(4);
		rd(`FPE_OFF_MODE, rv);
		chk("reset", 32'h0, {rv[30:0], write_check_mode});
		$display("test reset done");
		end_of_test();
	end

	// The tests take about 7000 cycles, most of it the erase pulse; this limit leaves a wide margin.
	initial begin
		#400000;
		miscompares++;
		end_of_test();
	end
endmodule
